// ===== rtl/saod_pkg.sv
package saod_pkg;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [12:0] IDX_CLAMP_CFG = 13'h02C6;
   localparam logic [12:0] IDX_JACK_EN   = 13'h02D3;
   localparam logic [12:0] IDX_FLAGS     = 13'h1806;
   localparam logic [12:0] IDX_MASKS     = 13'h1846;
   localparam logic [12:0] IDX_IRQ_CFG   = 13'h1A80;
   localparam logic [12:0] IDX_RST_PULL  = 13'h1AD0;
   localparam logic [12:0] IDX_AUX_PINS  = 13'h1AE0;

   // Byte-address bits that carry the register index.
   localparam int ADDR_IDX_LSB = 2;
   localparam int ADDR_IDX_MSB = 14;

   // Clamp configuration fields.
   localparam int CLAMP_SEL_LSB = 0;
   localparam int CLAMP_OVR_BIT = 4;

   // Jack sense enable fields.
   localparam int JACK_A_EN_BIT = 0;
   localparam int JACK_B_EN_BIT = 1;

   // Event flag and mask positions, shared by both registers.
   localparam int EV_A_RISE = 0;
   localparam int EV_A_FALL = 1;
   localparam int EV_B_RISE = 2;
   localparam int EV_B_FALL = 3;
   localparam int EV_C_RISE = 4;
   localparam int EV_C_FALL = 5;
   localparam int EV_NUM    = 6;

   // Interrupt output configuration fields.
   localparam int IRQ_MASK_BIT  = 0;
   localparam int INTERRUPT_OUT_POLARITY_BIT   = 1;
   localparam int IRQ_DRIVE_BIT = 2;

   // Reset pin pull fields.
   localparam int RST_PD_BIT = 0;
   localparam int RST_PU_BIT = 1;

   // Auxiliary pin register fields, each group four bits wide.
   localparam int AUX_OUT_LSB = 0;
   localparam int AUX_DIR_LSB = 4;
   localparam int AUX_IN_LSB  = 8;

   // Reset values.
   localparam logic [15:0] RST_CLAMP_CFG = 16'h0000;
   localparam logic [1:0]  RST_JACK_EN   = 2'h0;
   localparam logic [5:0]  RST_MASKS     = 6'h3F;
   localparam logic [2:0]  RST_IRQ_CFG   = 3'h1;
   localparam logic [1:0]  RST_RST_PULL  = 2'h2;

   // Clamp logic functions of the two jack status signals.
   typedef enum logic [3:0] {
      CLAMP_OFF     = 4'h0,
      CLAMP_A       = 4'h1,
      CLAMP_B       = 4'h2,
      CLAMP_A_AND_B = 4'h3,
      CLAMP_A_OR_B  = 4'h4,
      CLAMP_NOT_A   = 4'h5,
      CLAMP_NOT_B   = 4'h6,
      CLAMP_NEITHER = 4'h7
   } saod_clamp_t;

endpackage

// ===== rtl/saod_edge_flag.sv
// Sticky rise and fall flags for one status level.
module saod_edge_flag (
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic level_i,
   input  wire logic rise_clr_i,
   input  wire logic fall_clr_i,
   output logic      rise_flag_o,
   output logic      fall_flag_o
);

   logic prev_r;   // Level seen on the previous edge.
   logic rise_w;   // Level went from low to high.
   logic fall_w;   // Level went from high to low.

   assign rise_w = level_i & ~prev_r;
   assign fall_w = ~level_i & prev_r;

   // A new edge beats a clear in the same cycle so no event is lost.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prev_r      <= 1'b0;
         rise_flag_o <= 1'b0;
         fall_flag_o <= 1'b0;
      end else begin
         prev_r      <= level_i;
         rise_flag_o <= rise_w | (rise_flag_o & ~rise_clr_i);
         fall_flag_o <= fall_w | (fall_flag_o & ~fall_clr_i);
      end
   end

endmodule

// ===== rtl/saod_top.sv
// Notes on behaviour
// R1: Sleep whenever core supply is absent.
// R2: Jack sense changes raise events while asleep.
// R3: Host stops system and processor clocks first.
// R4: Always-on fields survive sleep, never reset.
// R5: No register access while asleep.
// R6: Host ends bus traffic before sleeping.
// R7: Non always-on inputs ignored while asleep.
// R8: Non always-on drivers and keepers off asleep.
// R9: Interrupt asleep only from jack events.
// R10: Interrupt asserted asleep holds until wake.
// R11: Enabled jack status follows its sense pin.
// R12: Clamp status is selectable function of statuses.
// R13: Jack and clamp statuses feed interrupt events.
// R14: Only core supply return wakes the device.
// R15: Host wakes device by restoring core supply.
// R16: Interrupt, sense inputs, reset stay alive.
// R17: Each edge sets masked sticky flag.
module saod_top #(
   parameter int AUX_W = 4   // Pins outside the always-on set.
) (
   input  wire logic                      clk_i,
   input  wire logic                      rst_b_i,
   input  wire logic                      core_supply_i,
   input  wire logic                      jack_sense_in_a_i,
   input  wire logic                      jack_sense_in_b_i,
   input  wire logic [AUX_W-1:0]          aux_in_i,
   input  wire logic                      hsel_i,
   input  wire logic [31:0]               haddr_i,
   input  wire logic [1:0]                htrans_i,
   input  wire logic                      hwrite_i,
   input  wire logic [2:0]                hsize_i,
   input  wire logic [31:0]               hwdata_i,
   input  wire logic                      hready_i,
   output logic      [31:0]               hrdata_o,
   output logic                           hreadyout_o,
   output logic                           hresp_o,
   output logic                           irq_o,
   output logic                           irq_oe_o,
   output logic                           jack_status_a_o,
   output logic                           jack_status_b_o,
   output logic                           clamp_status_o,
   output logic                           sleep_o,
   output logic                           reset_pin_pullup_o,
   output logic                           reset_pin_pulldown_o,
   output logic      [AUX_W-1:0]          aux_out_o,
   output logic      [AUX_W-1:0]          aux_oe_o,
   output logic                           aux_keeper_o
);
   import saod_pkg::*;

   // Always-on configuration; only the pin reset clears it, never sleep.
   logic [3:0]                clamp_logic_select_r;  // Clamp function.
   logic                      clamp_override_r;      // Forces clamp high.
   logic                      jack_status_a_en_r;    // Enables status a.
   logic                      jack_status_b_en_r;    // Enables status b.
   logic [EV_NUM-1:0]         ev_mask_r;             // One masks an event.
   logic                      interrupt_out_mask_r;  // Masks the pin.
   logic                      interrupt_out_polarity_r; // One: active high.
   logic                      interrupt_out_drive_cfg_r; // One: open drain.
   logic                      reset_pin_pullup_r;
   logic                      reset_pin_pulldown_r;

   // Core-domain auxiliary pin state.
   logic [AUX_W-1:0]          aux_lvl_r;   // Last level seen while awake.
   logic [AUX_W-1:0]          aux_out_r;   // Level to drive.
   logic [AUX_W-1:0]          aux_dir_r;   // One drives the pin.

   // Status, event and interrupt state.
   logic                      sleep_r;     // Core supply absent.
   logic                      irq_act_r;   // Interrupt request active.
   logic [EV_NUM-1:0]         ev_flag_w;   // Sticky event flags.
   logic [EV_NUM-1:0]         ev_clr_w;    // Write-one-to-clear pulses.

   // Bus data-phase state.
   logic                      wr_pend_r;   // Write data due this cycle.
   logic                      rd_pend_r;   // Read waiting one cycle.
   logic [12:0]               idx_r;       // Index captured at address.

   // Address phase decode.
   wire        addr_take_w = hsel_i & htrans_i[1] & hready_i;
   wire [12:0] addr_idx_w  = haddr_i[ADDR_IDX_MSB:ADDR_IDX_LSB];

   // Writes land only while awake; asleep the bus is not served.
   wire        wr_do_w     = wr_pend_r & ~sleep_r; // R5
   wire [15:0] wd_w        = hwdata_i[15:0];
   wire        wr_clamp_w  = wr_do_w & (idx_r == IDX_CLAMP_CFG);
   wire        wr_jack_w   = wr_do_w & (idx_r == IDX_JACK_EN);
   wire        wr_flags_w  = wr_do_w & (idx_r == IDX_FLAGS);
   wire        wr_masks_w  = wr_do_w & (idx_r == IDX_MASKS);
   wire        wr_irq_w    = wr_do_w & (idx_r == IDX_IRQ_CFG);
   wire        wr_pull_w   = wr_do_w & (idx_r == IDX_RST_PULL);
   wire        wr_aux_w    = wr_do_w & (idx_r == IDX_AUX_PINS);

   assign ev_clr_w = wr_flags_w ? wd_w[EV_NUM-1:0] : '0;

   // Jack status follows its pin only while enabled.
   wire stat_a_nxt = jack_status_a_en_r & jack_sense_in_a_i; // R11
   wire stat_b_nxt = jack_status_b_en_r & jack_sense_in_b_i; // R11

   // Clamp logic works on the present statuses.
   logic clamp_fn_w;
   always_comb begin
      case (saod_clamp_t'(clamp_logic_select_r)) // R12
         CLAMP_OFF:     clamp_fn_w = 1'b0;
         CLAMP_A:       clamp_fn_w = jack_status_a_o;
         CLAMP_B:       clamp_fn_w = jack_status_b_o;
         CLAMP_A_AND_B: clamp_fn_w = jack_status_a_o & jack_status_b_o;
         CLAMP_A_OR_B:  clamp_fn_w = jack_status_a_o | jack_status_b_o;
         CLAMP_NOT_A:   clamp_fn_w = ~jack_status_a_o;
         CLAMP_NOT_B:   clamp_fn_w = ~jack_status_b_o;
         CLAMP_NEITHER: clamp_fn_w = ~jack_status_a_o & ~jack_status_b_o;
         default:       clamp_fn_w = 1'b0;
      endcase
   end
   wire clamp_nxt = clamp_override_r | clamp_fn_w; // R12

   // Unmasked flags form the request; asleep it is held until wake.
   wire irq_raw_w   = (|(ev_flag_w & ~ev_mask_r)) & ~interrupt_out_mask_r;
   wire irq_act_nxt = irq_raw_w | (sleep_r & irq_act_r); // R9 R10

   // The pin shows the active level, or floats high-side in open drain.
   wire irq_pin_nxt = irq_act_nxt ? interrupt_out_polarity_r
                                  : ~interrupt_out_polarity_r;
   wire irq_oe_nxt  = ~interrupt_out_drive_cfg_r | irq_act_nxt;

   // Read mux, loaded in the wait cycle so it sees the latest write.
   logic [15:0] rd_val_w;
   always_comb begin
      rd_val_w = 16'h0000;
      case (idx_r)
         IDX_CLAMP_CFG: begin
            rd_val_w[CLAMP_SEL_LSB +: 4] = clamp_logic_select_r;
            rd_val_w[CLAMP_OVR_BIT]      = clamp_override_r;
         end
         IDX_JACK_EN: begin
            rd_val_w[JACK_A_EN_BIT] = jack_status_a_en_r;
            rd_val_w[JACK_B_EN_BIT] = jack_status_b_en_r;
         end
         IDX_FLAGS:    rd_val_w[EV_NUM-1:0] = ev_flag_w;
         IDX_MASKS:    rd_val_w[EV_NUM-1:0] = ev_mask_r;
         IDX_IRQ_CFG: begin
            rd_val_w[IRQ_MASK_BIT]  = interrupt_out_mask_r;
            rd_val_w[INTERRUPT_OUT_POLARITY_BIT]   = interrupt_out_polarity_r;
            rd_val_w[IRQ_DRIVE_BIT] = interrupt_out_drive_cfg_r;
         end
         IDX_RST_PULL: begin
            rd_val_w[RST_PD_BIT] = reset_pin_pulldown_r;
            rd_val_w[RST_PU_BIT] = reset_pin_pullup_r;
         end
         IDX_AUX_PINS: begin
            rd_val_w[AUX_OUT_LSB +: AUX_W] = aux_out_r;
            rd_val_w[AUX_DIR_LSB +: AUX_W] = aux_dir_r;
            rd_val_w[AUX_IN_LSB  +: AUX_W] = aux_lvl_r;
         end
         default:      rd_val_w = 16'h0000;
      endcase
   end

   // Bus slave: writes answer at once, reads add one wait cycle.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_pend_r   <= 1'b0;
         rd_pend_r   <= 1'b0;
         idx_r       <= 13'h0000;
         hrdata_o    <= 32'h00000000;
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end else begin
         wr_pend_r <= addr_take_w & hwrite_i;
         rd_pend_r <= addr_take_w & ~hwrite_i;
         if (addr_take_w) begin
            idx_r <= addr_idx_w;
         end
         hreadyout_o <= ~(addr_take_w & ~hwrite_i);
         if (rd_pend_r) begin
            hrdata_o <= sleep_r ? 32'h00000000 : {16'h0000, rd_val_w}; // R5
         end
      end
   end

   // Always-on registers; sleep entry leaves them untouched.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         clamp_logic_select_r <= RST_CLAMP_CFG[CLAMP_SEL_LSB +: 4];
         clamp_override_r     <= RST_CLAMP_CFG[CLAMP_OVR_BIT];
         jack_status_a_en_r   <= RST_JACK_EN[JACK_A_EN_BIT];
         jack_status_b_en_r   <= RST_JACK_EN[JACK_B_EN_BIT];
         ev_mask_r            <= RST_MASKS;
         interrupt_out_mask_r      <= RST_IRQ_CFG[IRQ_MASK_BIT];
         interrupt_out_polarity_r  <= RST_IRQ_CFG[INTERRUPT_OUT_POLARITY_BIT];
         interrupt_out_drive_cfg_r <= RST_IRQ_CFG[IRQ_DRIVE_BIT];
         reset_pin_pulldown_r <= RST_RST_PULL[RST_PD_BIT];
         reset_pin_pullup_r   <= RST_RST_PULL[RST_PU_BIT];
      end else begin
         // R4: no branch here depends on the sleep state itself.
         if (wr_clamp_w) begin
            clamp_logic_select_r <= wd_w[CLAMP_SEL_LSB +: 4];
            clamp_override_r     <= wd_w[CLAMP_OVR_BIT];
         end
         if (wr_jack_w) begin
            jack_status_a_en_r <= wd_w[JACK_A_EN_BIT];
            jack_status_b_en_r <= wd_w[JACK_B_EN_BIT];
         end
         if (wr_masks_w) begin
            ev_mask_r <= wd_w[EV_NUM-1:0];
         end
         if (wr_irq_w) begin
            interrupt_out_mask_r      <= wd_w[IRQ_MASK_BIT];
            interrupt_out_polarity_r  <= wd_w[INTERRUPT_OUT_POLARITY_BIT];
            interrupt_out_drive_cfg_r <= wd_w[IRQ_DRIVE_BIT];
         end
         if (wr_pull_w) begin
            reset_pin_pulldown_r <= wd_w[RST_PD_BIT];
            reset_pin_pullup_r   <= wd_w[RST_PU_BIT];
         end
      end
   end

   // Sleep state, statuses and the interrupt pin.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sleep_r              <= 1'b0;
         sleep_o              <= 1'b0;
         jack_status_a_o      <= 1'b0;
         jack_status_b_o      <= 1'b0;
         clamp_status_o       <= 1'b0;
         irq_act_r            <= 1'b0;
         irq_o                <= 1'b1;
         irq_oe_o             <= 1'b1;
         reset_pin_pullup_o   <= 1'b0;
         reset_pin_pulldown_o <= 1'b0;
      end else begin
         sleep_r              <= ~core_supply_i; // R1 R14
         sleep_o              <= ~core_supply_i;
         jack_status_a_o      <= stat_a_nxt;     // R16
         jack_status_b_o      <= stat_b_nxt;
         clamp_status_o       <= clamp_nxt;
         irq_act_r            <= irq_act_nxt;
         irq_o                <= irq_pin_nxt;    // R16
         irq_oe_o             <= irq_oe_nxt;
         reset_pin_pullup_o   <= reset_pin_pullup_r;
         reset_pin_pulldown_o <= reset_pin_pulldown_r;
      end
   end

   // Pins outside the always-on set: inputs frozen, drivers released.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         aux_lvl_r    <= '0;
         aux_out_r    <= '0;
         aux_dir_r    <= '0;
         aux_out_o    <= '0;
         aux_oe_o     <= '0;
         aux_keeper_o <= 1'b0;
      end else begin
         if (!sleep_r) begin
            aux_lvl_r <= aux_in_i; // R7
         end
         if (wr_aux_w) begin
            aux_out_r <= wd_w[AUX_OUT_LSB +: AUX_W];
            aux_dir_r <= wd_w[AUX_DIR_LSB +: AUX_W];
         end
         aux_out_o    <= aux_out_r;
         aux_oe_o     <= sleep_r ? '0 : aux_dir_r; // R8
         aux_keeper_o <= ~sleep_r;                 // R8
      end
   end

   // Three sources, each with a rise and a fall flag.
   saod_edge_flag u_flag_a (
      .clk_i       (clk_i),
      .rst_b_i     (rst_b_i),
      .level_i     (jack_status_a_o), // R2 R13 R17
      .rise_clr_i  (ev_clr_w[EV_A_RISE]),
      .fall_clr_i  (ev_clr_w[EV_A_FALL]),
      .rise_flag_o (ev_flag_w[EV_A_RISE]),
      .fall_flag_o (ev_flag_w[EV_A_FALL])
   );
   saod_edge_flag u_flag_b (
      .clk_i       (clk_i),
      .rst_b_i     (rst_b_i),
      .level_i     (jack_status_b_o), // R2 R13 R17
      .rise_clr_i  (ev_clr_w[EV_B_RISE]),
      .fall_clr_i  (ev_clr_w[EV_B_FALL]),
      .rise_flag_o (ev_flag_w[EV_B_RISE]),
      .fall_flag_o (ev_flag_w[EV_B_FALL])
   );
   saod_edge_flag u_flag_c (
      .clk_i       (clk_i),
      .rst_b_i     (rst_b_i),
      .level_i     (clamp_status_o),  // R13 R17
      .rise_clr_i  (ev_clr_w[EV_C_RISE]),
      .fall_clr_i  (ev_clr_w[EV_C_FALL]),
      .rise_flag_o (ev_flag_w[EV_C_RISE]),
      .fall_flag_o (ev_flag_w[EV_C_FALL])
   );

   // Checks kept beside the logic.
   property p_enter_sleep;
      @(posedge clk_i) disable iff (!rst_b_i)
      !core_supply_i |=> sleep_o ##1 !aux_keeper_o;
   endproperty
   a_enter_sleep: assert property (p_enter_sleep) // R1
      else $error("Sleep not entered after supply loss.");

   property p_no_jack_wake;
      @(posedge clk_i) disable iff (!rst_b_i)
      (sleep_r && !core_supply_i) |=> sleep_r;
   endproperty
   a_no_jack_wake: assert property (p_no_jack_wake) // R14
      else $error("Device woke without core supply.");

   property p_status_follow;
      @(posedge clk_i) disable iff (!rst_b_i)
      ##1 jack_status_a_o == $past(jack_status_a_en_r & jack_sense_in_a_i);
   endproperty
   a_status_follow: assert property (p_status_follow) // R11
      else $error("Jack status a does not follow its pin.");

   property p_rise_flag;
      @(posedge clk_i) disable iff (!rst_b_i)
      $rose(jack_status_b_o) |=> ev_flag_w[EV_B_RISE];
   endproperty
   a_rise_flag: assert property (p_rise_flag) // R17
      else $error("Rise of status b set no flag.");

   property p_clamp_override;
      @(posedge clk_i) disable iff (!rst_b_i)
      clamp_override_r |=> clamp_status_o;
   endproperty
   a_clamp_override: assert property (p_clamp_override) // R12
      else $error("Clamp override not honoured.");

   property p_irq_hold;
      @(posedge clk_i) disable iff (!rst_b_i)
      (sleep_r && irq_act_r) ##1 sleep_r |-> irq_act_r;
   endproperty
   a_irq_hold: assert property (p_irq_hold) // R10
      else $error("Interrupt dropped while asleep.");

   property p_no_write_asleep;
      @(posedge clk_i) disable iff (!rst_b_i)
      (wr_pend_r && sleep_r) |=> $stable(ev_mask_r) && $stable(aux_dir_r);
   endproperty
   a_no_write_asleep: assert property (p_no_write_asleep) // R5
      else $error("Register written while asleep.");

   property p_aux_floating;
      @(posedge clk_i) disable iff (!rst_b_i)
      sleep_r |=> aux_oe_o == '0 && !aux_keeper_o;
   endproperty
   a_aux_floating: assert property (p_aux_floating) // R8
      else $error("Outer pin driven while asleep.");

   property p_aux_ignored;
      @(posedge clk_i) disable iff (!rst_b_i)
      sleep_r |=> $stable(aux_lvl_r);
   endproperty
   a_aux_ignored: assert property (p_aux_ignored) // R7
      else $error("Outer input changed state while asleep.");

   property p_keep_on_sleep;
      @(posedge clk_i) disable iff (!rst_b_i)
      $rose(sleep_r) |-> $stable(ev_mask_r) && $stable(jack_status_a_en_r);
   endproperty
   a_keep_on_sleep: assert property (p_keep_on_sleep) // R4
      else $error("Always-on field changed on sleep entry.");

endmodule

// ===== bench/saod_host_model.sv
// Host processor side: it owns the core supply of the device.
module saod_host_model (
   input  wire logic clk_i,
   output logic      core_supply_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // The supply is present from power-up.
   initial core_supply_o = 1'b1;

   // The caller has already stopped its clocks and finished bus traffic.
   task automatic go_sleep();
      @(posedge clk_i);
      core_supply_o <= 1'b0;
   endtask

   // Restoring the supply is the only way to wake the device.
   task automatic wake();
      @(posedge clk_i);
      core_supply_o <= 1'b1;
   endtask
endmodule

// ===== bench/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import saod_pkg::*;

   logic        clk_i, rst_b_i, sense_a, sense_b, hsel, hwrite, core_supply;
   logic        hreadyout, hresp, irq, irq_oe, st_a, st_b, clamp, sleep;
   logic        pu, pd, keeper;
   logic [1:0]  htrans;
   logic [3:0]  aux_in, aux_out, aux_oe;
   logic [31:0] haddr, hwdata, hrdata, rdat;
   int          n_errors, cmp_count;

   saod_host_model host (.clk_i(clk_i), .core_supply_o(core_supply));

   saod_top uut (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .core_supply_i(core_supply),
      .jack_sense_in_a_i(sense_a), .jack_sense_in_b_i(sense_b),
      .aux_in_i(aux_in), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
      .hreadyout_o(hreadyout), .hresp_o(hresp), .irq_o(irq),
      .irq_oe_o(irq_oe), .jack_status_a_o(st_a), .jack_status_b_o(st_b),
      .clamp_status_o(clamp), .sleep_o(sleep),
      .reset_pin_pullup_o(pu), .reset_pin_pulldown_o(pd),
      .aux_out_o(aux_out), .aux_oe_o(aux_oe), .aux_keeper_o(keeper));

   // Free-running 200 MHz clock.
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic tally_and_finish();
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // Waits for ready at a rising edge; a hang ends the run as a failure.
   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge clk_i);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 20) begin
            n_errors++;
            tally_and_finish();
         end
         @(posedge clk_i);
      end
   endtask

   // One single word transfer; the read data lands in rdat.
   task automatic bus(input logic wr, input logic [12:0] idx,
                      input logic [15:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {17'h0, idx, 2'h0};
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {16'h0, wd};
      wait_ready();
      rdat = hrdata;
      chk("hresp", {31'h0, hresp}, 32'h0);
   endtask

   task automatic rchk(input string what, input logic [12:0] idx,
                       input logic [31:0] exp);
      bus(1'b0, idx, 16'h0000);
      chk(what, rdat, exp);
   endtask

   // Reset values, an unmapped place and the idle interrupt pin.
   task automatic t_reset();
      chk("pullup", {30'h0, pu, pd}, 32'h2);
      rchk("masks", IDX_MASKS, 32'h3F);
      rchk("irq cfg", IDX_IRQ_CFG, 32'h1);
      rchk("reset pull", IDX_RST_PULL, 32'h2);
      rchk("unmapped", 13'h0100, 32'h0);
      chk("irq idle", {30'h0, irq, irq_oe}, 32'h3);
   endtask

   // Enabled status follows its pin; a disabled one stays low.
   task automatic t_jack();
      bus(1'b1, IDX_JACK_EN, 16'h0001);
      bus(1'b1, IDX_MASKS, 16'h0000);
      bus(1'b1, IDX_IRQ_CFG, 16'h0000);
      sense_a <= 1'b1;
      sense_b <= 1'b1;
      cyc(4);
      chk("status", {30'h0, st_a, st_b}, 32'h2);
      chk("irq low", {31'h0, irq}, 32'h0);
      rchk("flags rise", IDX_FLAGS, 32'h01);
      bus(1'b1, IDX_IRQ_CFG, 16'h0002);
      cyc(2);
      chk("irq high", {31'h0, irq}, 32'h1);
      bus(1'b1, IDX_IRQ_CFG, 16'h0006);
      cyc(2);
      chk("irq open drain", {30'h0, irq, irq_oe}, 32'h3);
      bus(1'b1, IDX_FLAGS, 16'h003F);
      cyc(2);
      chk("irq od idle", {30'h0, irq, irq_oe}, 32'h0);
      bus(1'b1, IDX_IRQ_CFG, 16'h0000);
      cyc(2);
      chk("irq clear", {31'h0, irq}, 32'h1);
      sense_a <= 1'b0;
      cyc(4);
      rchk("flags fall", IDX_FLAGS, 32'h02);
   endtask

   // Every clamp function over every pair of statuses, then override.
   task automatic t_clamp();
      logic a, b, e;
      bus(1'b1, IDX_JACK_EN, 16'h0003);
      for (int c = 0; c < 4; c++) begin
         a = c[0];
         b = c[1];
         sense_a <= a;
         sense_b <= b;
         for (int m = 0; m < 9; m++) begin
            case (m)
               0: e = 1'b0;
               1: e = a;
               2: e = b;
               3: e = a & b;
               4: e = a | b;
               5: e = !a;
               6: e = !b;
               7: e = !a & !b;
               default: e = 1'b1;
            endcase
            bus(1'b1, IDX_CLAMP_CFG, (m == 8) ? 16'h0010 : 16'(m));
            cyc(3);
            chk("clamp", {31'h0, clamp}, {31'h0, e});
         end
      end
      bus(1'b1, IDX_CLAMP_CFG, 16'h0000);
      cyc(3);
      bus(1'b1, IDX_FLAGS, 16'h003F);
   endtask

   // Sleep: bus refused, outer pins off, interrupt held until wake.
   task automatic t_sleep();
      bus(1'b1, IDX_AUX_PINS, 16'h00F3);
      cyc(3);
      chk("aux awake", {23'h0, aux_out, aux_oe, keeper}, 32'h7F);
      rchk("aux pins", IDX_AUX_PINS, 32'h05F3);
      host.go_sleep();
      cyc(3);
      chk("sleep", {31'h0, sleep}, 32'h1);
      chk("aux off", {27'h0, aux_oe, keeper}, 32'h0);
      chk("irq quiet", {31'h0, irq}, 32'h1);
      aux_in <= 4'hA;
      bus(1'b0, IDX_MASKS, 16'h0000);
      chk("sleep read", rdat, 32'h0);
      bus(1'b1, IDX_MASKS, 16'h003F);
      sense_b <= 1'b0;
      cyc(4);
      chk("irq jack", {31'h0, irq}, 32'h0);
      bus(1'b1, IDX_FLAGS, 16'h003F);
      cyc(20);
      chk("irq held", {30'h0, irq, sleep}, 32'h1);
      host.wake();
      cyc(3);
      chk("awake", {31'h0, sleep}, 32'h0);
      chk("aux back", {27'h0, aux_oe, keeper}, 32'h1F);
      rchk("masks kept", IDX_MASKS, 32'h0);
      rchk("enable kept", IDX_JACK_EN, 32'h3);
      rchk("flags kept", IDX_FLAGS, 32'h08);
      bus(1'b1, IDX_FLAGS, 16'h003F);
      cyc(3);
      chk("irq released", {31'h0, irq}, 32'h1);
   endtask

   initial begin
      n_errors = 0;
      cmp_count = 0;
      rst_b_i = 1'b0;
      sense_a = 1'b0;
      sense_b = 1'b0;
      aux_in = 4'h5;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      cyc(3);
      rst_b_i <= 1'b1;
      cyc(2);
      t_reset();
      t_jack();
      t_clamp();
      t_sleep();
      tally_and_finish();
   end
endmodule
